// File: src/hmb_pkg.sv
package hmb_pkg;

  // register offsets
  localparam logic [7:0] HMB_OFS_HZONE   = 8'h19;
  localparam logic [7:0] HMB_OFS_MONITOR = 8'h1a;
  localparam logic [7:0] HMB_OFS_BUCK1   = 8'h1b;

  // field positions
  localparam int HMB_HZ_MODE_BIT    = 6;
  localparam int HMB_HZ_WARM_LSB    = 4;
  localparam int HMB_HZ_ROOM_LSB    = 2;
  localparam int HMB_HZ_COOL_LSB    = 0;
  localparam int HMB_MON_RATIO_LSB  = 5;
  localparam int HMB_MON_FLOAT_BIT  = 4;
  localparam int HMB_MON_CH_LSB     = 0;
  localparam int HMB_B1_SLOT_LSB    = 5;
  localparam int HMB_B1_RUN_LSB     = 0;

  // writable bits of each register
  localparam logic [7:0] HMB_HZ_WR_MASK  = 8'h7f;
  localparam logic [7:0] HMB_MON_WR_MASK = 8'h7f;
  localparam logic [7:0] HMB_B1_WR_MASK  = 8'h03;

  // reset values
  localparam logic [7:0] HMB_HZ_RESET  = 8'h3f;
  localparam logic [7:0] HMB_MON_RESET = 8'h00;
  localparam logic [7:0] HMB_B1_RESET  = 8'h00;

  // threshold arithmetic, in millivolts
  localparam logic [12:0] HMB_BASE_MV      = 13'h0fd2;
  localparam logic [12:0] HMB_STEP_MV      = 13'h0032;
  localparam logic [12:0] HMB_TRIM_STEP_MV = 13'h0032;
  localparam logic [3:0]  HMB_BASE_MAX     = 4'hb;
  localparam logic [1:0]  HMB_TRIM_NONE    = 2'h3;

  // monitor channel codes
  localparam logic [3:0] HMB_CH_OFF      = 4'h0;
  localparam logic [3:0] HMB_CH_LAST     = 4'h9;

  // thermal monitor enable codes
  localparam logic [1:0] HMB_THM_OFF       = 2'h0;
  localparam logic [1:0] HMB_THM_COOL_ROOM = 2'h1;
  localparam logic [1:0] HMB_THM_ROOM_WARM = 2'h2;
  localparam logic [1:0] HMB_THM_ALL       = 2'h3;

  // switch policy codes
  localparam logic [1:0] HMB_POL_DIRECT = 2'h0;
  localparam logic [1:0] HMB_POL_AUTO   = 2'h1;
  localparam logic [1:0] HMB_POL_IDEAL  = 2'h2;

  // buck1 boot slots
  localparam logic [2:0] HMB_SLOT_OFF  = 3'h0;
  localparam logic [2:0] HMB_SLOT_P0   = 3'h2;
  localparam logic [2:0] HMB_SLOT_P25  = 3'h3;
  localparam logic [2:0] HMB_SLOT_P50  = 3'h4;
  localparam logic [2:0] HMB_SLOT_RUN  = 3'h7;

  // buck1 run-control codes
  localparam logic [1:0] HMB_RUN_OFF = 2'h0;
  localparam logic [1:0] HMB_RUN_ON  = 2'h1;
  localparam logic [1:0] HMB_RUN_PIN = 2'h2;

  // boot milestone bits
  localparam int HMB_MS_P0   = 0;
  localparam int HMB_MS_P25  = 1;
  localparam int HMB_MS_P50  = 2;
  localparam int HMB_MS_P100 = 3;

  typedef enum logic [2:0] {
    HMB_ZONE_COLD = 3'b000,
    HMB_ZONE_COOL = 3'b001,
    HMB_ZONE_ROOM = 3'b010,
    HMB_ZONE_WARM = 3'b011,
    HMB_ZONE_HOT  = 3'b100
  } hmb_zone_e;

  typedef enum logic [1:0] {
    HMB_SW_DIRECT  = 2'b00,
    HMB_SW_AUTO    = 2'b01,
    HMB_SW_IDEAL   = 2'b10,
    HMB_SW_CHARGER = 2'b11
  } hmb_switch_e;

  typedef struct packed {
    logic       unused;
    logic       inhibit_mode;
    logic [1:0] warm_trim;
    logic [1:0] room_trim;
    logic [1:0] cool_trim;
  } hmb_hzone_s;

  typedef struct packed {
    logic       unused;
    logic [1:0] ratio;
    logic       off_float;
    logic [3:0] channel;
  } hmb_mon_s;

  typedef struct packed {
    logic [2:0] boot_slot;
    logic [2:0] unused;
    logic [1:0] run_control;
  } hmb_buck1_s;

  typedef struct packed {
    logic       charger_present;
    logic       interaction_enable;
    logic [1:0] thermal_enable;
    logic [3:0] base_threshold;
    logic [1:0] switch_policy;
  } hmb_harvest_s;

endpackage : hmb_pkg

// File: src/hmb_thresh_trim.sv
`timescale 1ns/1ps
`default_nettype none

module hmb_thresh_trim (
  // base code and zone trim
  input  wire logic [3:0]  base_code_in,
  input  wire logic [1:0]  trim_in,
  // resulting threshold
  output logic      [12:0] thresh_mv_out,
  output logic             valid_out
);
  import hmb_pkg::*;

  logic [12:0] base_mv;
  logic [12:0] reduction_mv;

  // each trim code step below 11 takes off one more 50 mV
  always_comb begin
    base_mv       = HMB_BASE_MV + 13'(HMB_STEP_MV * 13'(base_code_in));
    reduction_mv  = 13'(HMB_TRIM_STEP_MV * 13'(HMB_TRIM_NONE - trim_in));
    thresh_mv_out = base_mv - reduction_mv;
    valid_out     = (base_code_in <= HMB_BASE_MAX);
  end

endmodule : hmb_thresh_trim

`default_nettype wire

// File: src/hmb_regs.sv
`timescale 1ns/1ps
`default_nettype none

module hmb_regs (
  // clock and reset
  input  wire logic                 REF_CLK_IN,
  input  wire logic                 RESET_N_IN,
  // register access port
  input  wire logic [7:0]           REG_ADDR_IN,
  input  wire logic                 REG_WR_EN_IN,
  input  wire logic [7:0]           REG_WR_DATA_IN,
  input  wire logic                 REG_RD_EN_IN,
  output logic      [7:0]           REG_RD_DATA_OUT,
  output logic                      REG_RD_VALID_OUT,
  // harvester status from neighbouring logic
  input  wire hmb_pkg::hmb_harvest_s HARVEST_CFG_IN,
  input  wire hmb_pkg::hmb_zone_e    TEMP_ZONE_IN,
  // buck1 boot and control inputs
  input  wire logic [2:0]           BUCK1_BOOT_SLOT_STRAP_IN,
  input  wire logic [3:0]           BOOT_MILESTONE_IN,
  input  wire logic                 BUCK1_PIN_ENABLE_IN,
  input  wire logic                 POWER_DOWN_STATE_IN,
  // harvester outputs
  output logic                      HARVEST_DISABLE_PIN6_OUT,
  output hmb_pkg::hmb_switch_e      BAT_SYS_SWITCH_OUT,
  output logic      [12:0]          HARVEST_THRESH_MV_OUT,
  output logic                      HARVEST_THRESH_VALID_OUT,
  // monitor outputs
  output logic      [3:0]           MON_CHANNEL_OUT,
  output logic      [1:0]           MON_RATIO_OUT,
  output logic                      MON_PULLDOWN_OUT,
  output logic                      MON_FLOAT_OUT,
  // buck1 outputs
  output logic                      BUCK1_ENABLE_OUT,
  output logic                      BUCK1_DISCHARGE_OUT
);
  import hmb_pkg::*;

  hmb_hzone_s hzone_reg;
  hmb_mon_s   mon_reg;
  hmb_buck1_s buck1_reg;
  logic       strap_taken_reg;

  logic [1:0]  zone_trim;
  logic [12:0] thresh_mv;
  logic        thresh_valid;
  logic        monitor_on;
  logic        zone_allowed;
  logic        inhibit;
  logic        harvest_off_next;
  hmb_switch_e switch_next;
  logic        buck1_en_next;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction : addr_hit

  function automatic hmb_switch_e policy_to_switch(input logic [1:0] pol);
    case (pol)
      HMB_POL_DIRECT: policy_to_switch = HMB_SW_DIRECT;
      HMB_POL_AUTO:   policy_to_switch = HMB_SW_AUTO;
      HMB_POL_IDEAL:  policy_to_switch = HMB_SW_IDEAL;
      // reserved policy falls back to the plain direct path
      default:        policy_to_switch = HMB_SW_DIRECT;
    endcase
  endfunction : policy_to_switch

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      hzone_reg <= hmb_hzone_s'(HMB_HZ_RESET);
    end else if (REG_WR_EN_IN && addr_hit(REG_ADDR_IN, HMB_OFS_HZONE)) begin
      hzone_reg <= hmb_hzone_s'(REG_WR_DATA_IN & HMB_HZ_WR_MASK);
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mon_reg <= hmb_mon_s'(HMB_MON_RESET);
    end else if (REG_WR_EN_IN && addr_hit(REG_ADDR_IN, HMB_OFS_MONITOR)) begin
      mon_reg <= hmb_mon_s'(REG_WR_DATA_IN & HMB_MON_WR_MASK);
    end
  end

  // run control is software's; boot slot is loaded only from the strap
  // one process owns the whole register, so no field has two drivers
  // strap is caught at the first edge after release, not by the reset itself
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      buck1_reg       <= hmb_buck1_s'(HMB_B1_RESET);
      strap_taken_reg <= 1'b0;
    end else begin
      if (!strap_taken_reg) begin
        buck1_reg.boot_slot <= BUCK1_BOOT_SLOT_STRAP_IN;
        strap_taken_reg     <= 1'b1;
      end
      if (REG_WR_EN_IN && addr_hit(REG_ADDR_IN, HMB_OFS_BUCK1)) begin
        buck1_reg.run_control <= REG_WR_DATA_IN[HMB_B1_RUN_LSB +: 2] & HMB_B1_WR_MASK[HMB_B1_RUN_LSB +: 2];
        buck1_reg.unused      <= 3'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      REG_RD_DATA_OUT  <= 8'h00;
      REG_RD_VALID_OUT <= 1'b0;
    end else begin
      REG_RD_VALID_OUT <= REG_RD_EN_IN;
      if (!REG_RD_EN_IN) begin
        REG_RD_DATA_OUT <= 8'h00;
      end else if (addr_hit(REG_ADDR_IN, HMB_OFS_HZONE)) begin
        REG_RD_DATA_OUT <= 8'(hzone_reg) & HMB_HZ_WR_MASK;
      end else if (addr_hit(REG_ADDR_IN, HMB_OFS_MONITOR)) begin
        REG_RD_DATA_OUT <= 8'(mon_reg) & HMB_MON_WR_MASK;
      end else if (addr_hit(REG_ADDR_IN, HMB_OFS_BUCK1)) begin
        REG_RD_DATA_OUT <= {buck1_reg.boot_slot, 3'h0, buck1_reg.run_control};
      end else begin
        REG_RD_DATA_OUT <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // harvester zone handling
  // ---------------------------------------------------------------

  always_comb begin
    monitor_on = (HARVEST_CFG_IN.thermal_enable != HMB_THM_OFF);
    case (HARVEST_CFG_IN.thermal_enable)
      HMB_THM_COOL_ROOM: zone_allowed = (TEMP_ZONE_IN == HMB_ZONE_COOL) || (TEMP_ZONE_IN == HMB_ZONE_ROOM);
      HMB_THM_ROOM_WARM: zone_allowed = (TEMP_ZONE_IN == HMB_ZONE_ROOM) || (TEMP_ZONE_IN == HMB_ZONE_WARM);
      HMB_THM_ALL:       zone_allowed = (TEMP_ZONE_IN == HMB_ZONE_COOL) || (TEMP_ZONE_IN == HMB_ZONE_ROOM)
                                        || (TEMP_ZONE_IN == HMB_ZONE_WARM);
      default:           zone_allowed = 1'b1;
    endcase
  end

  assign inhibit = !HARVEST_CFG_IN.charger_present && HARVEST_CFG_IN.interaction_enable
                   && monitor_on && !zone_allowed;

  always_comb begin
    harvest_off_next = 1'b0;
    switch_next      = HMB_SW_DIRECT;
    if (HARVEST_CFG_IN.charger_present) begin
      harvest_off_next = HARVEST_CFG_IN.interaction_enable;
      switch_next      = HMB_SW_CHARGER;
    end else if (!HARVEST_CFG_IN.interaction_enable) begin
      switch_next = HMB_SW_DIRECT;
    end else if (inhibit && hzone_reg.inhibit_mode) begin
      harvest_off_next = 1'b0;
      switch_next      = HMB_SW_IDEAL;
    end else if (inhibit) begin
      harvest_off_next = 1'b1;
      switch_next      = policy_to_switch(HARVEST_CFG_IN.switch_policy);
    end else begin
      switch_next = policy_to_switch(HARVEST_CFG_IN.switch_policy);
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      HARVEST_DISABLE_PIN6_OUT <= 1'b0;
      BAT_SYS_SWITCH_OUT       <= HMB_SW_DIRECT;
    end else begin
      HARVEST_DISABLE_PIN6_OUT <= harvest_off_next;
      BAT_SYS_SWITCH_OUT       <= switch_next;
    end
  end

  // trims only mean something once the thermistor is watched
  always_comb begin
    zone_trim = HMB_TRIM_NONE;
    if (monitor_on) begin
      case (TEMP_ZONE_IN)
        HMB_ZONE_WARM: zone_trim = hzone_reg.warm_trim;
        HMB_ZONE_ROOM: zone_trim = hzone_reg.room_trim;
        HMB_ZONE_COOL: zone_trim = hzone_reg.cool_trim;
        default:       zone_trim = HMB_TRIM_NONE;
      endcase
    end
  end

  hmb_thresh_trim u_thresh (
    .base_code_in  (HARVEST_CFG_IN.base_threshold),
    .trim_in       (zone_trim),
    .thresh_mv_out (thresh_mv),
    .valid_out     (thresh_valid)
  );

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      HARVEST_THRESH_MV_OUT    <= 13'h0000;
      HARVEST_THRESH_VALID_OUT <= 1'b0;
    end else begin
      HARVEST_THRESH_MV_OUT    <= thresh_mv;
      HARVEST_THRESH_VALID_OUT <= thresh_valid;
    end
  end

  // ---------------------------------------------------------------
  // analog monitor multiplexer
  // ---------------------------------------------------------------

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      MON_CHANNEL_OUT  <= HMB_CH_OFF;
      MON_RATIO_OUT    <= 2'h0;
      MON_PULLDOWN_OUT <= 1'b1;
      MON_FLOAT_OUT    <= 1'b0;
    end else begin
      MON_CHANNEL_OUT  <= (mon_reg.channel <= HMB_CH_LAST) ? mon_reg.channel : HMB_CH_OFF;
      MON_RATIO_OUT    <= mon_reg.ratio;
      MON_PULLDOWN_OUT <= ((mon_reg.channel == HMB_CH_OFF) || (mon_reg.channel > HMB_CH_LAST))
                          && !mon_reg.off_float;
      MON_FLOAT_OUT    <= ((mon_reg.channel == HMB_CH_OFF) || (mon_reg.channel > HMB_CH_LAST))
                          && mon_reg.off_float;
    end
  end

  // ---------------------------------------------------------------
  // buck1 enable sequencing
  // ---------------------------------------------------------------

  always_comb begin
    buck1_en_next = 1'b0;
    case (buck1_reg.boot_slot)
      HMB_SLOT_P0:  buck1_en_next = BOOT_MILESTONE_IN[HMB_MS_P0];
      HMB_SLOT_P25: buck1_en_next = BOOT_MILESTONE_IN[HMB_MS_P25];
      HMB_SLOT_P50: buck1_en_next = BOOT_MILESTONE_IN[HMB_MS_P50];
      HMB_SLOT_RUN: begin
        if (BOOT_MILESTONE_IN[HMB_MS_P100]) begin
          case (buck1_reg.run_control)
            HMB_RUN_ON:  buck1_en_next = 1'b1;
            HMB_RUN_PIN: buck1_en_next = BUCK1_PIN_ENABLE_IN;
            default:     buck1_en_next = 1'b0;
          endcase
        end
      end
      default: buck1_en_next = 1'b0;
    endcase
    // power-down states always win over any enable
    if (POWER_DOWN_STATE_IN) begin
      buck1_en_next = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      BUCK1_ENABLE_OUT    <= 1'b0;
      BUCK1_DISCHARGE_OUT <= 1'b0;
    end else begin
      BUCK1_ENABLE_OUT    <= buck1_en_next;
      BUCK1_DISCHARGE_OUT <= POWER_DOWN_STATE_IN;
    end
  end

endmodule : hmb_regs

`default_nettype wire

// File: verif/hmb_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module hmb_regs_sva (
  // clock and reset
  input wire logic                  REF_CLK_IN,
  input wire logic                  RESET_N_IN,
  // register port
  input wire logic [7:0]            REG_ADDR_IN,
  input wire logic                  REG_WR_EN_IN,
  input wire logic [7:0]            REG_WR_DATA_IN,
  input wire logic                  REG_RD_EN_IN,
  input wire logic [7:0]            REG_RD_DATA_OUT,
  input wire logic                  REG_RD_VALID_OUT,
  // status inputs
  input wire hmb_pkg::hmb_harvest_s HARVEST_CFG_IN,
  input wire hmb_pkg::hmb_zone_e    TEMP_ZONE_IN,
  input wire logic [2:0]            BUCK1_BOOT_SLOT_STRAP_IN,
  input wire logic [3:0]            BOOT_MILESTONE_IN,
  input wire logic                  BUCK1_PIN_ENABLE_IN,
  input wire logic                  POWER_DOWN_STATE_IN,
  // outputs under watch
  input wire logic                  HARVEST_DISABLE_PIN6_OUT,
  input wire hmb_pkg::hmb_switch_e  BAT_SYS_SWITCH_OUT,
  input wire logic [12:0]           HARVEST_THRESH_MV_OUT,
  input wire logic                  HARVEST_THRESH_VALID_OUT,
  input wire logic [3:0]            MON_CHANNEL_OUT,
  input wire logic [1:0]            MON_RATIO_OUT,
  input wire logic                  MON_PULLDOWN_OUT,
  input wire logic                  MON_FLOAT_OUT,
  input wire logic                  BUCK1_ENABLE_OUT,
  input wire logic                  BUCK1_DISCHARGE_OUT
);
  import hmb_pkg::*;
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  rd_unmapped_a: assert property (REG_RD_EN_IN && !(REG_ADDR_IN inside {8'h19, 8'h1a, 8'h1b})
    |=> REG_RD_VALID_OUT && REG_RD_DATA_OUT == 8'h00) else $error("unmapped read not zero");
  rd_quiet_a: assert property (!REG_RD_EN_IN |=> !REG_RD_VALID_OUT && REG_RD_DATA_OUT == 8'h00)
    else $error("read data without request");
  buck_gap_a: assert property (REG_RD_EN_IN && REG_ADDR_IN == HMB_OFS_BUCK1
    |=> REG_RD_DATA_OUT[4:2] == 3'h0) else $error("buck1 unused bits set");
  charger_pin_a: assert property (HARVEST_CFG_IN.charger_present && HARVEST_CFG_IN.interaction_enable
    |=> HARVEST_DISABLE_PIN6_OUT && BAT_SYS_SWITCH_OUT == HMB_SW_CHARGER) else $error("charger pin six");
  no_interact_a: assert property (!HARVEST_CFG_IN.interaction_enable |=> !HARVEST_DISABLE_PIN6_OUT)
    else $error("pin six without interaction");
  mon_float_a: assert property (MON_FLOAT_OUT |-> MON_CHANNEL_OUT == 4'h0 && !MON_PULLDOWN_OUT)
    else $error("float with channel on");
  mon_pull_a: assert property (MON_PULLDOWN_OUT |-> MON_CHANNEL_OUT == 4'h0)
    else $error("pull-down with channel on");
  mon_range_a: assert property (MON_CHANNEL_OUT <= 4'h9) else $error("reserved channel");
  buck_down_a: assert property (POWER_DOWN_STATE_IN |=> !BUCK1_ENABLE_OUT)
    else $error("buck1 on in power-down");
  discharge_a: assert property (BUCK1_DISCHARGE_OUT |-> $past(POWER_DOWN_STATE_IN))
    else $error("discharge outside power-down");
  base_thresh_a: assert property (RESET_N_IN && HARVEST_CFG_IN.thermal_enable == 2'h0 &&
    HARVEST_CFG_IN.base_threshold <= 4'hb |=> HARVEST_THRESH_MV_OUT ==
    13'hfd2 + 13'h032 * {9'h000, $past(HARVEST_CFG_IN.base_threshold)}) else $error("base threshold");
  thresh_rsv_a: assert property (HARVEST_CFG_IN.base_threshold > 4'hb |=> !HARVEST_THRESH_VALID_OUT)
    else $error("reserved base marked valid");

  cover property (REG_WR_EN_IN && REG_ADDR_IN == HMB_OFS_MONITOR);
  cover property (HARVEST_DISABLE_PIN6_OUT && !HARVEST_CFG_IN.charger_present);
  cover property (BUCK1_ENABLE_OUT && !POWER_DOWN_STATE_IN);
  cover property (MON_FLOAT_OUT);
endmodule : hmb_regs_sva

bind hmb_regs hmb_regs_sva u_sva (.*);
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hmb_pkg::*;
  logic         REF_CLK_IN = 1'b0;
  logic         RESET_N_IN = 1'b0;
  logic [7:0]   REG_ADDR_IN = 8'h00, REG_WR_DATA_IN = 8'h00, REG_RD_DATA_OUT;
  logic         REG_WR_EN_IN = 1'b0, REG_RD_EN_IN = 1'b0, REG_RD_VALID_OUT;
  hmb_harvest_s HARVEST_CFG_IN = '0;
  hmb_zone_e    TEMP_ZONE_IN = HMB_ZONE_ROOM;
  logic [2:0]   BUCK1_BOOT_SLOT_STRAP_IN = 3'h7;
  logic [3:0]   BOOT_MILESTONE_IN = 4'hf, MON_CHANNEL_OUT;
  logic         BUCK1_PIN_ENABLE_IN = 1'b0, POWER_DOWN_STATE_IN = 1'b0;
  logic         HARVEST_DISABLE_PIN6_OUT, HARVEST_THRESH_VALID_OUT, MON_PULLDOWN_OUT, MON_FLOAT_OUT;
  logic         BUCK1_ENABLE_OUT, BUCK1_DISCHARGE_OUT;
  hmb_switch_e  BAT_SYS_SWITCH_OUT;
  logic [12:0]  HARVEST_THRESH_MV_OUT;
  logic [1:0]   MON_RATIO_OUT;
  logic [1:0]   trim [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  int           fail_count = 0, n_tests = 0, i;

  hmb_regs DUT (.*);
  always #50 REF_CLK_IN = ~REF_CLK_IN;

  task end_of_test;
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task chk(input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK_IN);
    REG_ADDR_IN    <= a;
    REG_WR_DATA_IN <= d;
    REG_WR_EN_IN   <= 1'b1;
    @(posedge REF_CLK_IN);
    REG_WR_EN_IN   <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge REF_CLK_IN);
    REG_ADDR_IN  <= a;
    REG_RD_EN_IN <= 1'b1;
    @(posedge REF_CLK_IN);
    REG_RD_EN_IN <= 1'b0;
    #1;
    chk(REG_RD_VALID_OUT, 1'b1);
    chk(REG_RD_DATA_OUT, exp);
  endtask : rd

  // two edges: one to latch, one for the outputs
  task st;
    repeat (2) @(posedge REF_CLK_IN);
    #1;
  endtask : st

  task hv(input logic [9:0] h, input logic [2:0] z);
    @(posedge REF_CLK_IN);
    HARVEST_CFG_IN <= h;
    TEMP_ZONE_IN   <= hmb_zone_e'(z);
    st();
  endtask : hv

  task rst(input logic [2:0] s);
    @(posedge REF_CLK_IN);
    RESET_N_IN               <= 1'b0;
    BUCK1_BOOT_SLOT_STRAP_IN <= s;
    repeat (10) @(posedge REF_CLK_IN);
    RESET_N_IN               <= 1'b1;
  endtask : rst

  initial begin
    repeat (20000) @(posedge REF_CLK_IN);
    fail_count++;
    end_of_test();
  end

  initial begin
    rst(3'h7);
    rd(HMB_OFS_HZONE, 8'h3f);
    rd(HMB_OFS_MONITOR, 8'h00);
    rd(HMB_OFS_BUCK1, 8'he0);
    wr(HMB_OFS_HZONE, 8'hff);
    wr(HMB_OFS_MONITOR, 8'hff);
    wr(HMB_OFS_BUCK1, 8'h1c);
    wr(8'h18, 8'hff);
    rd(HMB_OFS_HZONE, 8'h7f);
    rd(HMB_OFS_MONITOR, 8'h7f);
    rd(HMB_OFS_BUCK1, 8'he0);
    rd(8'h18, 8'h00);
    rd(8'h1c, 8'h00);
    // reserved channels behave as off
    for (i = 0; i < 32; i++) begin
      wr(HMB_OFS_MONITOR, {1'b0, i[1:0], i[4], i[3:0]});
      st();
      chk(MON_CHANNEL_OUT, (i[3:0] <= 4'h9) ? i[3:0] : 4'h0);
      chk(MON_RATIO_OUT, i[1:0]);
      chk(MON_PULLDOWN_OUT, (i[3:0] == 4'h0 || i[3:0] > 4'h9) && !i[4]);
      chk(MON_FLOAT_OUT, (i[3:0] == 4'h0 || i[3:0] > 4'h9) && i[4]);
    end
    // warm 00, room 01, cool 10; cold takes no trim
    wr(HMB_OFS_HZONE, 8'h06);
    for (i = 0; i < 4; i++) begin
      hv({2'b00, HMB_THM_ALL, 4'h2, HMB_POL_AUTO}, i[2:0]);
      chk(HARVEST_THRESH_MV_OUT, 13'h1036 - 13'h032 * (13'h3 - trim[i]));
      chk(HARVEST_THRESH_VALID_OUT, 1'b1);
    end
    hv({2'b00, HMB_THM_OFF, 4'hb, HMB_POL_AUTO}, 3'h3);
    chk(HARVEST_THRESH_MV_OUT, 13'h11f8);
    hv({2'b00, HMB_THM_OFF, 4'hc, HMB_POL_AUTO}, 3'h3);
    chk(HARVEST_THRESH_VALID_OUT, 1'b0);
    hv({2'b01, HMB_THM_COOL_ROOM, 4'h2, HMB_POL_AUTO}, 3'h4);
    chk(HARVEST_DISABLE_PIN6_OUT, 1'b1);
    chk(BAT_SYS_SWITCH_OUT, HMB_SW_AUTO);
    wr(HMB_OFS_HZONE, 8'h46);
    st();
    chk(HARVEST_DISABLE_PIN6_OUT, 1'b0);
    chk(BAT_SYS_SWITCH_OUT, HMB_SW_IDEAL);
    hv({2'b01, HMB_THM_COOL_ROOM, 4'h2, HMB_POL_AUTO}, 3'h2);
    chk(BAT_SYS_SWITCH_OUT, HMB_SW_AUTO);
    hv({2'b01, HMB_THM_COOL_ROOM, 4'h2, HMB_POL_IDEAL}, 3'h2);
    chk(BAT_SYS_SWITCH_OUT, HMB_SW_IDEAL);
    hv({2'b01, HMB_THM_COOL_ROOM, 4'h2, 2'h3}, 3'h2);
    chk(BAT_SYS_SWITCH_OUT, HMB_SW_DIRECT);
    hv({2'b11, HMB_THM_COOL_ROOM, 4'h2, HMB_POL_AUTO}, 3'h4);
    chk(HARVEST_DISABLE_PIN6_OUT, 1'b1);
    chk(BAT_SYS_SWITCH_OUT, HMB_SW_CHARGER);
    hv({2'b10, HMB_THM_COOL_ROOM, 4'h2, HMB_POL_AUTO}, 3'h4);
    chk(HARVEST_DISABLE_PIN6_OUT, 1'b0);
    for (i = 0; i < 8; i++) begin
      @(posedge REF_CLK_IN);
      BUCK1_PIN_ENABLE_IN <= i[2];
      wr(HMB_OFS_BUCK1, {6'h00, i[1:0]});
      st();
      chk(BUCK1_ENABLE_OUT, i[1:0] == 2'h1 || (i[1:0] == 2'h2 && i[2]));
      chk(BUCK1_DISCHARGE_OUT, 1'b0);
    end
    wr(HMB_OFS_BUCK1, 8'h01);
    @(posedge REF_CLK_IN);
    BOOT_MILESTONE_IN <= 4'h7;
    st();
    chk(BUCK1_ENABLE_OUT, 1'b0);
    @(posedge REF_CLK_IN);
    BOOT_MILESTONE_IN   <= 4'hf;
    POWER_DOWN_STATE_IN <= 1'b1;
    st();
    chk(BUCK1_ENABLE_OUT, 1'b0);
    chk(BUCK1_DISCHARGE_OUT, 1'b1);
    // second boot with the 0% slot
    @(posedge REF_CLK_IN);
    POWER_DOWN_STATE_IN <= 1'b0;
    BOOT_MILESTONE_IN   <= 4'h0;
    rst(3'h2);
    wr(HMB_OFS_BUCK1, 8'hfd);
    rd(HMB_OFS_BUCK1, 8'h41);
    chk(BUCK1_ENABLE_OUT, 1'b0);
    @(posedge REF_CLK_IN);
    BOOT_MILESTONE_IN <= 4'h1;
    st();
    chk(BUCK1_ENABLE_OUT, 1'b1);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
